/* logic/mdsic_consts.svh */
// Constants of the motor driver serial interface configuration block
`ifndef MDSIC_CONSTS_SVH
`define MDSIC_CONSTS_SVH
`define MDSIC_CLK_NS 8
`define MDSIC_T_ON_PH_NS 3600
`define MDSIC_T_OFF_PH_NS 3000
`define MDSIC_T_ON_CK_NS 4200
`define MDSIC_T_OFF_CK_NS 3600
`define MDSIC_CYC(ns) (((ns) + `MDSIC_CLK_NS - 1) / `MDSIC_CLK_NS)
`define MDSIC_DLY_W 10
`define MDSIC_FRAME_BITS 9
`define MDSIC_ADDR_MAX 5'h1E
`define MDSIC_ADDR_BCAST 5'h1F
`define MDSIC_SET_RST 4'h0
`define MDSIC_STEP_BIT 0
`define MDSIC_DIR_BIT 1
`define MDSIC_EN_BIT 2
`define MDSIC_SYNC_W 21
`endif

/* logic/mdsic_pkg.sv */
// Types shared by the serial interface configuration block
package mdsic_pkg;
    typedef enum logic [1:0] {MDSIC_IF_NONE, MDSIC_IF_LVDS, MDSIC_IF_3W, MDSIC_IF_4W} mdsic_iface_t;
    typedef struct packed {
        logic driver_mode_strap;
        logic sensor_output_style_strap;
        logic iface_strap_first;
        logic iface_strap_second;
        logic [4:0] address_straps;
    } mdsic_straps_t;
    typedef struct packed {
        logic clk_pos;
        logic clk_neg;
        logic dat_pos;
        logic dat_neg;
    } mdsic_fwd_t;
    typedef struct packed {
        logic overcurrent_protect;
        logic thermal_shutdown;
    } mdsic_fault_t;
endpackage : mdsic_pkg

/* logic/mdsic_sync.sv */
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module mdsic_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    // First stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic sync_q;
        always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= d_i[i];
                sync_q <= meta_q;
            end
        end
        assign q_o[i] = sync_q;
    end
endmodule : mdsic_sync

/* logic/mdsic_outdelay.sv */
// Turn-on and turn-off delay of one driver transistor gate
`timescale 1ns/1ns
`include "mdsic_consts.svh"
module mdsic_outdelay (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    // Control
    input wire logic tgt_i,
    input wire logic clock_mode_i,
    // Gate
    output logic gate_o
);
    import mdsic_pkg::*;
    localparam logic [`MDSIC_DLY_W-1:0] ON_PH = `MDSIC_DLY_W'(`MDSIC_CYC(`MDSIC_T_ON_PH_NS));
    localparam logic [`MDSIC_DLY_W-1:0] OFF_PH = `MDSIC_DLY_W'(`MDSIC_CYC(`MDSIC_T_OFF_PH_NS));
    localparam logic [`MDSIC_DLY_W-1:0] ON_CK = `MDSIC_DLY_W'(`MDSIC_CYC(`MDSIC_T_ON_CK_NS));
    localparam logic [`MDSIC_DLY_W-1:0] OFF_CK = `MDSIC_DLY_W'(`MDSIC_CYC(`MDSIC_T_OFF_CK_NS));
    logic [`MDSIC_DLY_W-1:0] cnt_q;
    logic [`MDSIC_DLY_W-1:0] on_len;
    logic [`MDSIC_DLY_W-1:0] off_len;
    logic gate_q;

    // Delays differ per driver mode
    assign on_len = clock_mode_i ? ON_CK : ON_PH;
    assign off_len = clock_mode_i ? OFF_CK : OFF_PH;

    // A new target restarts nothing; a reverted one cancels the pending change
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            gate_q <= 1'b0;
        end else if (clr_i) begin
            cnt_q <= '0;
            gate_q <= 1'b0;
        end else if (tgt_i == gate_q) begin
            cnt_q <= '0;
        end else if (cnt_q == '0) begin
            cnt_q <= tgt_i ? on_len : off_len;
        end else if (cnt_q == `MDSIC_DLY_W'(1)) begin
            gate_q <= tgt_i;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q - `MDSIC_DLY_W'(1);
        end
    end
    assign gate_o = gate_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_GATE_AT_END: assert property (!$stable(gate_q) && !$past(clr_i) |-> $past(cnt_q) == 1)
        else $error("gate moved before its delay ran out");
    AST_LOAD_LEN: assert property ((cnt_q == 0) && (tgt_i != gate_q) && !clr_i
        |=> cnt_q == ($past(tgt_i) ? $past(on_len) : $past(off_len)))
        else $error("delay loaded with the wrong length");
    AST_OFF_SHORTER: assert property (off_len < on_len)
        else $error("turn-off delay not shorter than turn-on");
endmodule : mdsic_outdelay

/* logic/mdsic_top.sv */
// Serial interface configuration and control of a stepping-motor driver
// Behaviour
// - Gates change only through setting writes taken from the forward link, or clear on power down.
// - Driver-mode strap high selects clock input mode, low phase input mode.
// - Sensor-style strap high: reverse output push-pull; low: open drain.
// - First strap high, second low: differential forward and reverse links.
// - Second strap high: single-ended forward data and clock on positive pins.
// - Four-wire mode: active-low select, clock and data in, return styled by the output-style strap.
// - In single-ended input modes, negative data pin is the output-style strap.
// - Output-style high: single-ended outputs, negatives unused; low: differential.
// - Received forward clock and data are re-driven to the next device.
// - Four-wire input can be bridged onto differential forward outputs.
// - Own address from five straps; addresses above 30 never match.
// - Broadcast writes apply whatever the address strap.
// - Four sensor inputs sampled together and shifted out on reverse link.
// - Power-down high: low power and internal logic held in reset.
// - Fault output pulled low on overcurrent or thermal shutdown, else released.
// - Written setting reaches the gates after a timed delay.
// - Turn-off shorter than turn-on gives dead time with both off.
`timescale 1ns/1ns
`include "mdsic_consts.svh"
module mdsic_top (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Straps and power down
    input wire mdsic_pkg::mdsic_straps_t straps_i,
    input wire logic power_down_in_i,
    // Forward link in and out
    input wire mdsic_pkg::mdsic_fwd_t fwd_in_i,
    output mdsic_pkg::mdsic_fwd_t fwd_out_o,
    // Reverse link
    input wire logic rev_serial_in_pos_i,
    output logic rev_serial_out_pos_o,
    output logic rev_serial_out_oe_o,
    output logic rev_serial_out_neg_o,
    // Sensors, faults and gates
    input wire logic [3:0] sensor_inputs_i,
    input wire mdsic_pkg::mdsic_fault_t faults_i,
    output logic [3:0] gate_o,
    output logic fault_out_n_o,
    output logic fault_out_oe_o,
    output logic low_power_o
);
    import mdsic_pkg::*;

    typedef enum logic {ST_IDLE, ST_SHIFT} mdsic_state_t;

    logic [`MDSIC_SYNC_W-1:0] raw_w;
    logic [`MDSIC_SYNC_W-1:0] syn_w;
    mdsic_straps_t straps_s;
    logic pd_s;
    mdsic_fwd_t fwd_s;
    logic rev_in_s;
    logic [3:0] sens_s;
    mdsic_fault_t flt_s;
    mdsic_iface_t iface_w;
    logic output_style_strap_s;
    logic diff_out_w;
    logic sclk_w;
    logic sdat_w;
    logic cs_n_w;
    logic clk_prev_q;
    logic dat_prev_q;
    logic cs_prev_q;
    logic clk_rise_w;
    logic clk_fall_w;
    logic start_w;
    logic abort_w;
    logic commit_w;
    logic hit_w;
    logic [8:0] word_w;
    mdsic_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] frame_q;
    logic [3:0] set_q;
    logic wr_q;
    logic [1:0] phase_q;
    logic [3:0] sens_sh_q;
    logic rev_bit_w;
    logic [3:0] target_w;
    logic fault_oe_q;
    mdsic_fwd_t fwd_out_q;
    logic rev_pos_q;
    logic rev_oe_q;
    logic rev_neg_q;

    // Every pin passes two flops before use
    assign raw_w = {straps_i, power_down_in_i, fwd_in_i, rev_serial_in_pos_i, sensor_inputs_i, faults_i};
    mdsic_sync #(.W(`MDSIC_SYNC_W)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .d_i(raw_w),
        .q_o(syn_w)
    );
    assign {straps_s, pd_s, fwd_s, rev_in_s, sens_s, flt_s} = syn_w;

    // Interface select from the two straps
    always_comb begin
        unique case ({straps_s.iface_strap_first, straps_s.iface_strap_second})
            2'b10: iface_w = MDSIC_IF_LVDS;
            2'b01: iface_w = MDSIC_IF_3W;
            2'b11: iface_w = MDSIC_IF_4W;
            2'b00: iface_w = MDSIC_IF_NONE;
        endcase
    end

    // Negative data pin turns into a strap in single-ended modes
    assign output_style_strap_s = fwd_s.dat_neg;
    assign diff_out_w = (iface_w == MDSIC_IF_LVDS) || !output_style_strap_s;

    // Receiver outputs; differential pairs are resolved by the analog front end
    assign sclk_w = fwd_s.clk_pos;
    assign sdat_w = fwd_s.dat_pos;
    assign cs_n_w = fwd_s.clk_neg;

    // Edge history of the received link
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_prev_q <= 1'b0;
            dat_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= sclk_w;
            dat_prev_q <= sdat_w;
            cs_prev_q <= cs_n_w;
        end
    end
    assign clk_rise_w = sclk_w && !clk_prev_q;
    assign clk_fall_w = !sclk_w && clk_prev_q;

    // Frame start: select falling, or data falling while clock is high
    always_comb begin
        unique case (iface_w)
            MDSIC_IF_4W: start_w = cs_prev_q && !cs_n_w;
            MDSIC_IF_LVDS, MDSIC_IF_3W: start_w = sclk_w && dat_prev_q && !sdat_w;
            MDSIC_IF_NONE: start_w = 1'b0;
        endcase
    end
    assign abort_w = (iface_w == MDSIC_IF_4W) && cs_n_w;

    // Frame shifter; power down holds it idle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            frame_q <= 8'h00;
        end else if (pd_s) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            frame_q <= 8'h00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_w) begin
                        state_q <= ST_SHIFT;
                        bit_cnt_q <= 4'h0;
                    end
                end
                ST_SHIFT: begin
                    if (abort_w) begin
                        state_q <= ST_IDLE;
                    end else if (clk_rise_w) begin
                        frame_q <= {frame_q[6:0], sdat_w};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (commit_w) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Last bit completes the word: five address bits then four setting bits
    assign commit_w = (state_q == ST_SHIFT) && clk_rise_w && !abort_w && !pd_s
        && (bit_cnt_q == 4'(`MDSIC_FRAME_BITS - 1));
    assign word_w = {frame_q, sdat_w};
    assign hit_w = (word_w[8:4] == `MDSIC_ADDR_BCAST)
        || ((word_w[8:4] == straps_s.address_straps) && (straps_s.address_straps <= `MDSIC_ADDR_MAX));

    // Setting register written only by a matching frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            set_q <= `MDSIC_SET_RST;
            wr_q <= 1'b0;
        end else if (pd_s) begin
            set_q <= `MDSIC_SET_RST;
            wr_q <= 1'b0;
        end else begin
            wr_q <= commit_w && hit_w;
            if (commit_w && hit_w) begin
                set_q <= word_w[3:0];
            end
        end
    end

    // Clock input mode: each write may step the excitation phase
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= 2'h0;
        end else if (pd_s) begin
            phase_q <= 2'h0;
        end else if (wr_q && straps_s.driver_mode_strap && set_q[`MDSIC_EN_BIT] && set_q[`MDSIC_STEP_BIT]) begin
            phase_q <= set_q[`MDSIC_DIR_BIT] ? phase_q - 2'h1 : phase_q + 2'h1;
        end
    end

    // Two-phase excitation pattern, bits {B1, B0, A1, A0}
    function automatic logic [3:0] mdsic_pattern(input logic [1:0] ph);
        logic [3:0] p;
        p = 4'h5;
        unique case (ph)
            2'h0: p = 4'h5;
            2'h1: p = 4'h6;
            2'h2: p = 4'hA;
            2'h3: p = 4'h9;
        endcase
        return p;
    endfunction : mdsic_pattern

    // Phase mode drives the setting bits straight to the gates
    assign target_w = straps_s.driver_mode_strap
        ? (set_q[`MDSIC_EN_BIT] ? mdsic_pattern(phase_q) : 4'h0)
        : set_q;

    // One delay stage per transistor gate
    for (genvar i = 0; i < 4; i++) begin : g_gate
        mdsic_outdelay u_dly (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .clr_i(pd_s),
            .tgt_i(target_w[i]),
            .clock_mode_i(straps_s.driver_mode_strap),
            .gate_o(gate_o[i])
        );
    end

    // Sensors captured at frame start; the fall before the first rise is skipped so bit 3 meets the first rise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sens_sh_q <= 4'hF;
        end else if (pd_s) begin
            sens_sh_q <= 4'hF;
        end else if (state_q == ST_IDLE && start_w) begin
            sens_sh_q <= sens_s;
        end else if (state_q == ST_SHIFT && clk_fall_w && (bit_cnt_q != 4'h0)) begin
            sens_sh_q <= {sens_sh_q[2:0], rev_in_s};
        end
    end
    assign rev_bit_w = sens_sh_q[3];

    // Reverse driver; open drain only ever pulls low
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rev_pos_q <= 1'b0;
            rev_oe_q <= 1'b0;
            rev_neg_q <= 1'b0;
        end else begin
            rev_pos_q <= straps_s.sensor_output_style_strap ? rev_bit_w : 1'b0;
            rev_oe_q <= straps_s.sensor_output_style_strap || !rev_bit_w;
            rev_neg_q <= diff_out_w ? !rev_bit_w : 1'b0;
        end
    end
    assign rev_serial_out_pos_o = rev_pos_q;
    assign rev_serial_out_oe_o = rev_oe_q;
    assign rev_serial_out_neg_o = rev_neg_q;

    // Repeater re-times clock and data; four-wire select idles both high
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fwd_out_q <= '0;
        end else begin
            fwd_out_q.clk_pos <= abort_w ? 1'b1 : sclk_w;
            fwd_out_q.dat_pos <= abort_w ? 1'b1 : sdat_w;
            fwd_out_q.clk_neg <= diff_out_w && !(abort_w ? 1'b1 : sclk_w);
            fwd_out_q.dat_neg <= diff_out_w && !(abort_w ? 1'b1 : sdat_w);
        end
    end
    assign fwd_out_o = fwd_out_q;

    // Fault pin only sinks, so its level is fixed low
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_oe_q <= 1'b0;
        end else begin
            fault_oe_q <= flt_s.overcurrent_protect || flt_s.thermal_shutdown;
        end
    end
    assign fault_out_oe_o = fault_oe_q;
    assign fault_out_n_o = 1'b0;
    assign low_power_o = pd_s;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_frame_start;
        (state_q == ST_IDLE) && start_w && !pd_s ##1 (state_q == ST_SHIFT);
    endsequence
    sequence seq_pd_held;
        pd_s [*2];
    endsequence

    AST_PD_RESET: assert property (seq_pd_held |-> (state_q == ST_IDLE) && (set_q == 4'h0) && !wr_q)
        else $error("power down did not hold logic in reset");
    AST_SET_ONLY_WRITE: assert property (!$stable(set_q) && !$past(pd_s) |-> $past(commit_w && hit_w))
        else $error("setting changed without a matching write");
    AST_ADDR_HIT: assert property (commit_w && hit_w |=> wr_q && (set_q == $past(word_w[3:0])))
        else $error("matching write not applied");
    AST_ADDR_MISS: assert property (commit_w && (word_w[8:4] != 5'h1F) && (straps_s.address_straps > 5'h1E)
        |=> !wr_q)
        else $error("write accepted by an out-of-range address");
    AST_REV_OD: assert property (!$past(straps_s.sensor_output_style_strap)
        |-> !rev_serial_out_pos_o && (rev_serial_out_oe_o == !$past(rev_bit_w)))
        else $error("open-drain reverse output drove high");
    AST_FWD_STYLE: assert property (!$past(diff_out_w) |-> !fwd_out_o.clk_neg && !fwd_out_o.dat_neg)
        else $error("negative forward pins driven in single-ended style");
    AST_REPEAT: assert property ((iface_w == MDSIC_IF_LVDS) ##1 (iface_w == MDSIC_IF_LVDS)
        |-> (fwd_out_o.clk_pos == $past(sclk_w)) && (fwd_out_o.clk_neg == !$past(sclk_w)))
        else $error("forward clock not re-driven");
    AST_FAULT: assert property ((flt_s.overcurrent_protect || flt_s.thermal_shutdown) |=> fault_out_oe_o)
        else $error("fault output not pulled low on a fault");
    AST_NOIF: assert property ((iface_w == MDSIC_IF_NONE) && (state_q == ST_IDLE) |=> state_q == ST_IDLE)
        else $error("frame started with no interface selected");
    AST_SENS_LOAD: assert property (seq_frame_start |-> sens_sh_q == $past(sens_s))
        else $error("sensors not captured at frame start");
endmodule : mdsic_top

/* tb/mdsic_host_model.sv */
// Behavioural host that drives the forward link and reads the reverse return
`timescale 1ns/1ns
module mdsic_host_model
    import mdsic_pkg::*;
(
    // Link mode as strapped on the device
    input wire logic four_wire_i,
    input wire logic lvds_i,
    input wire logic output_style_strap_i,
    // Reverse wire level after the pull-up
    input wire logic rev_wire_i,
    // Forward link towards the device
    output mdsic_pkg::mdsic_fwd_t fwd_o
);
    logic clk_q = 1'b1;
    logic dat_q = 1'b1;
    logic cs_n_q = 1'b1;

    // Negative pins: inverse pair, select, held low clock or output-style level
    assign fwd_o.clk_pos = clk_q;
    assign fwd_o.dat_pos = dat_q;
    assign fwd_o.clk_neg = lvds_i ? ~clk_q : (four_wire_i ? cs_n_q : 1'b0);
    assign fwd_o.dat_neg = lvds_i ? ~dat_q : output_style_strap_i;

    // One frame; clock stands high between frames, select released early at bit ab
    // Pins move by non-blocking assignment, so a change that meets a core clock edge lands after it
    task automatic send(input logic [8:0] word, input int ab, output logic [4:0] rx);
        rx = 5'h00;
        if (four_wire_i) cs_n_q <= 1'b0;
        else dat_q <= 1'b0;
        #63;
        for (int i = 8; i >= 0; i--) begin
            clk_q <= 1'b0;
            dat_q <= word[i];
            if (i == ab) cs_n_q <= 1'b1;
            #62;
            clk_q <= 1'b1;
            if (i >= 4) rx = {rx[3:0], rev_wire_i};
            #63;
        end
        clk_q <= 1'b0;
        dat_q <= 1'b1;
        #62;
        clk_q <= 1'b1;
        cs_n_q <= 1'b1;
        #250;
    endtask : send
endmodule : mdsic_host_model

/* tb/mdsic_top_bench.sv */
// Self-checking bench for the serial interface configuration block
`timescale 1ns/1ns
module mdsic_top_bench;
    import mdsic_pkg::*;
    logic core_clk_i, rst_i, pd, rev_in, output_style_strap, mon_en, fw, diff, rev_wire;
    logic rev_pos, rev_oe, rev_neg, fout_n, fout_oe, low_pw;
    logic [3:0] sens, gate, exp_gate;
    logic [3:0] pats [4] = '{4'h5, 4'h6, 4'hA, 4'h9};
    logic [3:0] steps [7] = '{4'hD, 4'h5, 4'h5, 4'h7, 4'h4, 4'h0, 4'h5};
    mdsic_straps_t straps;
    mdsic_fwd_t fwd_in, fwd_out, e2, e3;
    mdsic_fwd_t hist [4];
    mdsic_fault_t faults;
    int fails = 0;
    int n_compared = 0;
    int phase, rnd, own;

    // Mode decode seen from the bench, and the reverse wire with its pull-up
    assign fw = straps.iface_strap_first & straps.iface_strap_second;
    assign diff = ~straps.iface_strap_second | ~output_style_strap;
    assign rev_wire = rev_oe ? rev_pos : 1'b1;

    // Factory test input is tied low on the board, so no pin of it reaches the block
    mdsic_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .straps_i(straps), .power_down_in_i(pd),
        .fwd_in_i(fwd_in), .fwd_out_o(fwd_out), .rev_serial_in_pos_i(rev_in), .rev_serial_out_pos_o(rev_pos),
        .rev_serial_out_oe_o(rev_oe), .rev_serial_out_neg_o(rev_neg), .sensor_inputs_i(sens),
        .faults_i(faults), .gate_o(gate), .fault_out_n_o(fout_n), .fault_out_oe_o(fout_oe), .low_power_o(low_pw));
    mdsic_host_model u_host (.four_wire_i(fw), .lvds_i(straps.iface_strap_first & ~straps.iface_strap_second),
        .output_style_strap_i(output_style_strap), .rev_wire_i(rev_wire), .fwd_o(fwd_in));

    // Core clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic done(input string name);
        $display("Test %s finished", name);
    endtask : done

    // Expected repeater output; in four-wire an idle select holds both lines high
    function automatic mdsic_fwd_t rep(input mdsic_fwd_t h);
        logic c, d;
        c = h.clk_pos | (fw & h.clk_neg);
        d = h.dat_pos | (fw & h.clk_neg);
        return '{c, diff & ~c, d, diff & ~d};
    endfunction : rep

    // Reference of the gate target: straight bits, or a stepped four-phase table
    task automatic model(input logic [3:0] s);
        if (!straps.driver_mode_strap) exp_gate = s;
        else begin
            if (s[2] && s[0]) phase = s[1] ? (phase + 3) % 4 : (phase + 1) % 4;
            exp_gate = s[2] ? pats[phase] : 4'h0;
        end
    endtask : model

    // Straps are synced pins, so give them a long quiet spell before traffic
    task automatic set_mode(input logic [1:0] im, input logic om, input logic dm, input logic [4:0] a);
        mon_en = 1'b0;
        straps = '{dm, 1'($urandom), im[1], im[0], a};
        output_style_strap = om;
        own = a;
        repeat (600) tick();
        mon_en = (im != 2'b00);
    endtask : set_mode

    // One frame, then follow the gates long enough for both delays to expire
    task automatic write(input logic [4:0] a, input logic [3:0] s, input logic take, input int ab);
        logic [4:0] rx;
        logic [3:0] prev;
        int t_on, t_off, on_c;
        sens = 4'($urandom);
        rev_in = 1'($urandom);
        repeat (4) tick();
        prev = gate;
        u_host.send({a, s}, ab, rx);
        if (!pd && straps.iface_strap_first | straps.iface_strap_second) check({4'h0, rx}, {4'h0, sens, rev_in});
        if (take) model(s);
        t_on = -1;
        t_off = -1;
        on_c = straps.driver_mode_strap ? 525 : 450;
        for (int t = 0; t < 700; t++) begin
            tick();
            if (t_on < 0 && (gate & ~prev) != 4'h0) t_on = t;
            if (t_off < 0 && (prev & ~gate) != 4'h0) t_off = t;
        end
        check({5'h00, gate}, {5'h00, exp_gate});
        if (t_on >= 0) check(9'(t_on > on_c - 60 && t_on < on_c - 30), 9'h001);
        if (t_on >= 0 && t_off >= 0) check(9'(t_on - t_off), 9'd75);
    endtask : write

    // History of the link as the core clock sees it
    always @(posedge core_clk_i) begin
        for (int k = 3; k > 0; k--) hist[k] = hist[k - 1];
        hist[0] = fwd_in;
    end

    // Repeater and reverse pin style; sync phase allows one edge of slack
    always @(negedge core_clk_i) begin
        if (mon_en) begin
            e2 = rep(hist[2]);
            e3 = rep(hist[3]);
            check({5'h00, fwd_out}, (fwd_out === e3) ? {5'h00, e3} : {5'h00, e2});
            check({6'h00, rev_oe, rev_pos, rev_neg}, straps.sensor_output_style_strap ?
                {6'h00, 1'b1, rev_pos, diff & ~rev_pos} : {6'h00, rev_oe, 1'b0, diff & rev_oe});
        end
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        pd = 1'b0;
        rev_in = 1'b0;
        sens = 4'h0;
        faults = '0;
        output_style_strap = 1'b0;
        mon_en = 1'b0;
        straps = '0;
        phase = 0;
        exp_gate = 4'h0;
        rnd = $urandom(49051);
        repeat (16) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        repeat (4) tick();
        check({4'h0, low_pw, gate}, 9'h000);
        for (int m = 1; m < 4; m++) begin
            for (int o = 0; o < 2; o++) begin
                set_mode(2'(m), 1'(o), 1'b0, 5'($urandom % 31));
                write(5'(own), 4'($urandom), 1'b1, -1);
                write(5'((own + 1) % 31), 4'($urandom), 1'b0, -1);
                write(5'h1F, 4'($urandom), 1'b1, -1);
            end
        end
        done("modes");
        set_mode(2'b10, 1'b0, 1'b1, 5'h1E);
        foreach (steps[i]) write(5'h1E, steps[i], 1'b1, -1);
        set_mode(2'b10, 1'b0, 1'b1, 5'h1F);
        write(5'h1F, 4'h5, 1'b1, -1);
        write(5'h1E, 4'h5, 1'b0, -1);
        done("clock mode and address");
        set_mode(2'b00, 1'b0, 1'b1, 5'h03);
        write(5'h03, 4'h5, 1'b0, -1);
        set_mode(2'b11, 1'b1, 1'b1, 5'h03);
        write(5'h03, 4'h7, 1'b0, 3);
        done("idle decode and abort");
        pd = 1'b1;
        mon_en = 1'b0;
        repeat (5) tick();
        check({4'h0, low_pw, gate}, 9'h010);
        phase = 0;
        exp_gate = 4'h0;
        write(5'h03, 4'h5, 1'b0, -1);
        pd = 1'b0;
        repeat (4) tick();
        mon_en = 1'b1;
        write(5'h03, 4'h5, 1'b1, -1);
        done("power down");
        for (int f = 0; f < 4; f++) begin
            faults = 2'(f);
            repeat (4) tick();
            check({7'h00, fout_n, fout_oe}, {8'h00, f != 0});
        end
        done("faults");
        tally_and_finish();
    end

    // Hang guard
    initial begin
        #800000;
        fails++;
        tally_and_finish();
    end
endmodule : mdsic_top_bench
